//--- hdl/i2c_tgt_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module i2c_tgt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // write side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // read side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_r[wp_r] <= i_in_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

//--- hdl/i2c_tgt_params.svh
// constants for the i2c target status and acknowledge control block
`ifndef I2C_TGT_PARAMS_SVH
`define I2C_TGT_PARAMS_SVH
`define FLAG_W        14
`define F_TXREQ       0
`define F_RXRDY       1
`define F_ADDRV       2
`define F_ACKDEC      3
`define F_RESTART     4
`define F_STOP        5
`define F_BITERR      6
`define F_FIFOERR     7
`define F_HIT0        8
`define F_HIT1        9
`define F_BCAST       10
`define F_TACTIVE     11
`define F_BUSOCC      12
`define F_RSVD        13
`define CLEARABLE     14'h00f0
`define IRQ_CAPABLE   14'h07ff
`define MASK_RST      14'h0000
`define MATCH_ONE     2'h0
`define MATCH_EITHER  2'h1
`define MATCH_RANGE   2'h2
`define FIFO_DEPTH    8
`define BCAST_ADDR    7'h00
`endif

//--- hdl/i2c_tgt_pkg.sv
// types for the i2c target status and acknowledge control block
package i2c_tgt_pkg;
  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_DRIVE} ack_state_e;
endpackage

//--- hdl/i2c_tgt_status_ctrl.sv
// i2c target status flags, masks, dma requests, address capture and ack hold
`timescale 1ns/1ps
`include "i2c_tgt_params.svh"
// What this block does
// R1 - keeps thirteen target status flags for data, address, ack, events, errors, busy
// R2 - only restart, stop, bit error and fifo error flags can be cleared
// R3 - every flag except busy indications can raise interrupt under own mask
// R4 - mask bits read back in the status flag layout
// R5 - three separately enabled dma requests: address valid, receive, transmit
// R6 - address valid request shares the receive data request line
// R7 - bus busy reads meaningful only while target operation is enabled
// R8 - ack decision flag only with ack hold; waits for software answer
// R9 - software ack choice: one drives ack, other drives nak
// R10 - control bit turns ack holding on; software then decides ack
// R11 - captured address byte: direction bit 0, address bits 7 to 1
// R12 - software reads captured address only while address valid is set
// R13 - with ack hold, scl held low at ninth bit until answered
// R14 - match first address, either address, or range first through second
// R15 - writing one clears a clearable flag; zero has no effect
module i2c_tgt_status_ctrl #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // configuration
  input  wire logic                 i_target_enable,
  input  wire logic                 i_ack_hold_enable,
  input  wire logic [1:0]           i_match_mode,
  input  wire logic [6:0]           i_addr0,
  input  wire logic [6:0]           i_addr1,
  input  wire logic                 i_bcast_enable,
  input  wire logic                 i_dma_addr_en,
  input  wire logic                 i_dma_rx_en,
  input  wire logic                 i_dma_tx_en,
  // flag clear and mask writes
  input  wire logic                 i_clear_strobe,
  input  wire logic [`FLAG_W-1:0]   i_clear_bits,
  input  wire logic                 i_mask_we,
  input  wire logic [`FLAG_W-1:0]   i_mask_wdata,
  // software ack answer
  input  wire logic                 i_ack_we,
  input  wire logic                 i_ack_nak,
  // events from the bus engine (same clock)
  input  wire logic                 i_addr_byte_valid,
  input  wire logic [7:0]           i_addr_byte,
  input  wire logic                 i_ninth_bit,
  input  wire logic                 i_rx_byte_valid,
  input  wire logic [7:0]           i_rx_byte,
  output logic                      o_rx_ready,
  input  wire logic                 i_tx_wanted,
  input  wire logic                 i_restart_seen,
  input  wire logic                 i_stop_seen,
  input  wire logic                 i_bit_error,
  input  wire logic                 i_bus_busy,
  // software receive data side
  input  wire logic                 i_rx_pop,
  output logic [7:0]                o_rx_data,
  // status outputs
  output logic [`FLAG_W-1:0]        o_status,
  output logic [`FLAG_W-1:0]        o_mask,
  output logic                      o_irq,
  output logic [7:0]                o_addr_captured,
  output logic                      o_dma_rx_req,
  output logic                      o_dma_tx_req,
  // bus drive to the engine
  output logic                      o_scl_hold,
  output logic                      o_ack_valid,
  output logic                      o_ack_nak
);
  logic [`FLAG_W-1:0]     flags_r;
  logic [`FLAG_W-1:0]     flags_nxt;
  logic [`FLAG_W-1:0]     mask_r;
  logic [7:0]             addr_r;
  logic                   hit_r;
  logic                   active_r;
  logic                   ack_nak_r;
  i2c_tgt_pkg::ack_state_e ack_st_r;
  logic                   f_in_ready;
  logic                   f_out_valid;
  logic [7:0]             f_out_data;
  logic                   hit0;
  logic                   hit1;
  logic                   hitb;
  logic [2:0]             cap_hits;

  // match decode
  function automatic logic [2:0] match(input logic [6:0] a, input logic [1:0] m,
                                       input logic [6:0] a0, input logic [6:0] a1, input logic be);
    logic h0;
    logic h1;
    h0 = 1'b0;
    h1 = 1'b0;
    unique case (m)
      `MATCH_EITHER:
      begin
        h0 = (a == a0);
        h1 = (a == a1);
      end
      `MATCH_RANGE:
        h0 = (a >= a0) && (a <= a1);
      default:
        h0 = (a == a0);
    endcase
    match = {be && (a == `BCAST_ADDR), h1, h0};
  endfunction

  // R14 address matching
  assign {hitb, hit1, hit0} = match(i_addr_byte[7:1], i_match_mode, i_addr0, i_addr1, i_bcast_enable);
  // R14 match kinds of the captured address
  assign cap_hits = match(addr_r[7:1], i_match_mode, i_addr0, i_addr1, i_bcast_enable);

  i2c_tgt_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (i_rx_byte_valid && i_target_enable),
    .i_in_data   (i_rx_byte),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_out_valid),
    .o_out_data  (f_out_data),
    .i_out_ready (i_rx_pop)
  );

  // R11 address capture on a match
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      addr_r <= 8'h00;
      hit_r  <= 1'b0;
    end
    else if (i_addr_byte_valid && i_target_enable && (hit0 || hit1 || hitb))
    begin
      addr_r <= i_addr_byte;
      hit_r  <= 1'b1;
    end
    else if (i_stop_seen)
      hit_r  <= 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      active_r <= 1'b0;
    else if (i_stop_seen || !i_target_enable)
      active_r <= 1'b0;
    else if (i_addr_byte_valid && (hit0 || hit1 || hitb))
      active_r <= 1'b1;
  end

  // R8 R10 R13 ack holding sequence
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ack_st_r  <= i2c_tgt_pkg::ACK_IDLE;
      ack_nak_r <= 1'b0;
    end
    else
    begin
      unique case (ack_st_r)
        i2c_tgt_pkg::ACK_IDLE:
          if (i_ninth_bit && i_ack_hold_enable && active_r)
            ack_st_r <= i2c_tgt_pkg::ACK_WAIT;
        i2c_tgt_pkg::ACK_WAIT:
          // R9 software ack choice
          if (i_ack_we)
          begin
            ack_nak_r <= i_ack_nak;
            ack_st_r  <= i2c_tgt_pkg::ACK_DRIVE;
          end
        i2c_tgt_pkg::ACK_DRIVE:
          ack_st_r <= i2c_tgt_pkg::ACK_IDLE;
      endcase
    end
  end

  // R1 R2 R15 flag update, set wins over clear
  always_comb
  begin
    flags_nxt = flags_r;
    if (i_clear_strobe)
      flags_nxt = flags_r & ~(i_clear_bits & `CLEARABLE);
    if (i_restart_seen)
      flags_nxt[`F_RESTART] = 1'b1;
    if (i_stop_seen)
      flags_nxt[`F_STOP] = 1'b1;
    if (i_bit_error)
      flags_nxt[`F_BITERR] = 1'b1;
    if (i_rx_byte_valid && i_target_enable && !f_in_ready)
      flags_nxt[`F_FIFOERR] = 1'b1;
    flags_nxt[`F_TXREQ]   = i_tx_wanted && active_r;
    flags_nxt[`F_RXRDY]   = f_out_valid;
    flags_nxt[`F_ADDRV]   = hit_r;
    flags_nxt[`F_ACKDEC]  = (ack_st_r == i2c_tgt_pkg::ACK_WAIT);
    flags_nxt[`F_HIT0]    = hit_r && cap_hits[0];
    flags_nxt[`F_HIT1]    = hit_r && cap_hits[1];
    flags_nxt[`F_BCAST]   = hit_r && cap_hits[2];
    flags_nxt[`F_TACTIVE] = active_r;
    // R7 bus busy only meaningful while enabled
    flags_nxt[`F_BUSOCC]  = i_bus_busy && i_target_enable;
    flags_nxt[`F_RSVD]    = 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  // R3 R4 mask register
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      mask_r <= `MASK_RST;
    else if (i_mask_we)
      mask_r <= i_mask_wdata & `IRQ_CAPABLE;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_irq        <= 1'b0;
      o_dma_rx_req <= 1'b0;
      o_dma_tx_req <= 1'b0;
      o_scl_hold   <= 1'b0;
      o_ack_valid  <= 1'b0;
      o_ack_nak    <= 1'b0;
      o_rx_ready   <= 1'b0;
      o_rx_data    <= 8'h00;
    end
    else
    begin
      // R3 masked interrupt
      o_irq        <= |(flags_nxt & mask_r & `IRQ_CAPABLE);
      // R5 R6 dma requests, address shares receive line
      o_dma_rx_req <= (i_dma_rx_en && flags_nxt[`F_RXRDY]) || (i_dma_addr_en && flags_nxt[`F_ADDRV]);
      o_dma_tx_req <= i_dma_tx_en && flags_nxt[`F_TXREQ];
      // R13 hold scl while waiting
      o_scl_hold   <= ((ack_st_r == i2c_tgt_pkg::ACK_WAIT) && !i_ack_we)
                      || ((ack_st_r == i2c_tgt_pkg::ACK_IDLE) && i_ninth_bit && i_ack_hold_enable && active_r);
      o_ack_valid  <= (ack_st_r == i2c_tgt_pkg::ACK_WAIT) && i_ack_we;
      o_ack_nak    <= i_ack_we ? i_ack_nak : ack_nak_r;
      o_rx_ready   <= f_in_ready;
      o_rx_data    <= f_out_data;
    end
  end

  assign o_status        = flags_r;
  assign o_mask          = mask_r;
  assign o_addr_captured = addr_r;

  clear_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clear_strobe && !i_restart_seen && flags_r[`F_RESTART] && i_clear_bits[`F_RESTART]
    |=> !flags_r[`F_RESTART]) else $error("restart flag not cleared"); // R2 R15
  set_wins_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_stop_seen |=> flags_r[`F_STOP]) else $error("stop flag lost"); // R15
  ackdec_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    flags_r[`F_ACKDEC] |-> o_scl_hold || o_ack_valid) else $error("ack decision without hold"); // R8 R13
  ackdec_en_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(flags_r[`F_ACKDEC]) |-> $past(i_ack_hold_enable, 2)) else $error("ack decision without enable"); // R8 R10
  busy_masked_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_target_enable |=> !flags_r[`F_BUSOCC]) else $error("bus busy while disabled"); // R7
  mask_bits_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_mask_we |=> mask_r[`F_TACTIVE] == 1'b0 && mask_r[`F_BUSOCC] == 1'b0) else $error("busy maskable"); // R3 R4
  dma_share_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_dma_addr_en && flags_nxt[`F_ADDRV] |=> o_dma_rx_req) else $error("address dma missing"); // R5 R6
  ack_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ack_st_r == i2c_tgt_pkg::ACK_WAIT && i_ack_we |=> o_ack_valid && o_ack_nak == $past(i_ack_nak)
    ) else $error("ack answer wrong"); // R9
  no_hold_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ack_st_r == i2c_tgt_pkg::ACK_IDLE && !i_ack_hold_enable |=> !o_scl_hold) else $error("hold without enable"); // R10 R13
  addr_cap_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_addr_byte_valid && i_target_enable && hit0 |=> addr_r == $past(i_addr_byte) ##1 flags_r[`F_ADDRV]
    ) else $error("address not captured"); // R11

  ack_cycle_c: cover property (@(posedge i_clock) ack_st_r == i2c_tgt_pkg::ACK_WAIT ##[1:20] o_ack_valid);
  irq_c: cover property (@(posedge i_clock) o_irq);
  fifo_err_c: cover property (@(posedge i_clock) flags_r[`F_FIFOERR]);
endmodule

//--- verif/i2c_ctrl_model.sv
// behavioural bus engine standing in for the far-side controller
`timescale 1ns/1ps
module i2c_ctrl_model (
  // clock and stretch
  input  wire logic       i_clock,
  input  wire logic       i_scl_hold,
  // bus events
  output logic            o_addr_v,
  output logic            o_data_v,
  output logic      [7:0] o_byte,
  output logic            o_ninth,
  output logic      [2:0] o_evt
);
  initial
  begin
    {o_addr_v, o_data_v, o_ninth, o_evt} = 6'h00;
    o_byte = 8'ha5;
  end
  // pulse restart, stop, bit error
  task automatic pulse(input logic [2:0] e);
    @(posedge i_clock);
    o_evt <= e;
    @(posedge i_clock);
    o_evt <= 3'h0;
  endtask
  // one byte, its ninth bit, then wait out a stretch of up to 100 cycles
  task automatic send_byte(input logic is_addr, input logic [7:0] b);
    int n;
    @(posedge i_clock);
    o_addr_v <= is_addr;
    o_data_v <= !is_addr;
    o_byte <= b;
    @(posedge i_clock);
    {o_addr_v, o_data_v, o_ninth} <= 3'h1;
    // stale byte shows its inverse
    o_byte <= ~b;
    @(posedge i_clock);
    o_ninth <= 1'b0;
    n = 0;
    @(negedge i_clock);
    while (i_scl_hold === 1'b1 && n < 100)
    begin
      @(negedge i_clock);
      n++;
    end
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the i2c target status and ack control block
`timescale 1ns/1ps
`include "i2c_tgt_params.svh"
module tb_top;
  logic              i_clock = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_target_enable = 1'b0, i_ack_hold_enable = 1'b0, i_dma_addr_en = 1'b0, i_dma_tx_en = 1'b0;
  logic              i_clear_strobe = 1'b0, i_mask_we = 1'b0, i_ack_we = 1'b0, i_ack_nak = 1'b0;
  logic              i_rx_pop = 1'b0, i_tx_wanted = 1'b0, i_bus_busy = 1'b0, i_bcast_enable = 1'b0, i_dma_rx_en = 1'b0;
  logic [1:0]        i_match_mode = 2'h0;
  logic [6:0]        i_addr0 = 7'h10, i_addr1 = 7'h18;
  logic [13:0]       i_clear_bits = 14'h0000, i_mask_wdata = 14'h0000;
  logic              i_addr_byte_valid, i_ninth_bit, i_rx_byte_valid, o_rx_ready, o_irq;
  logic              o_dma_rx_req, o_dma_tx_req, o_scl_hold, o_ack_valid, o_ack_nak;
  logic [2:0]        evt;
  logic [7:0]        bus_byte, o_rx_data, o_addr_captured;
  logic [13:0]       o_status, o_mask;
  int                bad_count = 0, comparisons = 0;
  logic              exp_q[$];
  logic [1:0]        t_mode[5] = '{`MATCH_ONE, `MATCH_ONE, `MATCH_EITHER, `MATCH_RANGE, `MATCH_RANGE};
  logic [3:0]        t_off[5] = '{4'h0, 4'h8, 4'h8, 4'h3, 4'h9};
  logic              t_hit[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  always #10 i_clock = ~i_clock;
  i2c_tgt_status_ctrl #(.DEPTH(`FIFO_DEPTH)) dut (
    .i_clock, .i_rst, .i_target_enable, .i_ack_hold_enable, .i_match_mode, .i_addr0, .i_addr1,
    .i_bcast_enable, .i_dma_addr_en, .i_dma_rx_en, .i_dma_tx_en, .i_clear_strobe,
    .i_clear_bits, .i_mask_we, .i_mask_wdata, .i_ack_we, .i_ack_nak, .i_addr_byte_valid,
    .i_addr_byte(bus_byte), .i_ninth_bit, .i_rx_byte_valid, .i_rx_byte(bus_byte), .o_rx_ready,
    .i_tx_wanted, .i_restart_seen(evt[0]), .i_stop_seen(evt[1]), .i_bit_error(evt[2]), .i_bus_busy,
    .i_rx_pop, .o_rx_data, .o_status, .o_mask, .o_irq, .o_addr_captured, .o_dma_rx_req,
    .o_dma_tx_req, .o_scl_hold, .o_ack_valid, .o_ack_nak);
  i2c_ctrl_model model (
    .i_clock, .i_scl_hold(o_scl_hold), .o_addr_v(i_addr_byte_valid), .o_data_v(i_rx_byte_valid),
    .o_byte(bus_byte), .o_ninth(i_ninth_bit), .o_evt(evt));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic look(input int n);
    tick(n);
    @(negedge i_clock);
  endtask
  task automatic cmp(input string what, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobe: 0 clear, 1 mask load, 2 ack answer
  task automatic wr(input int k, input logic [13:0] v);
    @(posedge i_clock);
    if (k == 0) {i_clear_strobe, i_clear_bits} <= {1'b1, v};
    if (k == 1) {i_mask_we, i_mask_wdata} <= {1'b1, v};
    if (k == 2) {i_ack_we, i_ack_nak} <= {1'b1, v[0]};
    if (k == 2) exp_q.push_back(v[0]);
    @(posedge i_clock);
    {i_clear_strobe, i_mask_we, i_ack_we} <= 3'h0;
  endtask
  task automatic tally_and_finish;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge i_clock)
    if (o_ack_valid === 1'b1)
      cmp("ack nak", exp_q.size() > 0 ? 14'(exp_q.pop_front()) : 14'h3fff, 14'(o_ack_nak));
  initial
  begin
    #100us;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [13:0] m;
    logic [7:0] b;
    logic [7:0] d[`FIFO_DEPTH+1];
    void'($urandom(32'h862cf010));
    tick(10);
    i_rst <= 1'b0;
    look(1);
    cmp("status", 14'h0000, o_status);
    cmp("mask", `MASK_RST, o_mask);
    tick(1);
    {i_target_enable, i_bus_busy} <= 2'h3;
    b = 8'($urandom_range(16, 100));
    i_addr0 <= b[6:0];
    i_addr1 <= b[6:0] + 7'h08;
    model.pulse(3'h7);
    look(3);
    cmp("sticky", 14'h1070, o_status & 14'h10f0);
    wr(0, ~`CLEARABLE);
    look(3);
    cmp("clear other", 14'h1070, o_status & 14'h10f0);
    wr(0, 14'h0020);
    look(3);
    cmp("clear stop", 14'h1050, o_status & 14'h10f0);
    m = 14'($urandom());
    wr(1, m);
    look(2);
    cmp("mask", m & `IRQ_CAPABLE, o_mask);
    wr(1, 14'h0010);
    look(3);
    cmp("irq on", 14'h0001, 14'(o_irq));
    wr(1, 14'h3800);
    look(3);
    cmp("irq off", 14'h0000, 14'(o_irq));
    wr(0, `CLEARABLE);
    i_target_enable <= 1'b0;
    look(3);
    cmp("busy off", 14'h0000, o_status & 14'h10f0);
    tick(1);
    {i_target_enable, i_tx_wanted, i_dma_tx_en} <= 3'h7;
    // transmit request only shows while the target is addressed
    model.send_byte(1'b1, {i_addr0, 1'b1});
    look(3);
    cmp("tx dma", 14'h0001, 14'(o_dma_tx_req));
    cmp("tx flag", 14'h0001, o_status & 14'h0001);
    model.pulse(3'h2);
    tick(1);
    {i_tx_wanted, i_dma_addr_en} <= 2'h1;
    for (int i = 0; i < 5; i++)
    begin
      tick(1);
      i_match_mode <= t_mode[i];
      b = {i_addr0 + 7'(t_off[i]), 1'($urandom())};
      model.send_byte(1'b1, b);
      look(2);
      cmp("addr valid", 14'(t_hit[i]), 14'(o_status[`F_ADDRV]));
      cmp("addr dma", 14'(t_hit[i]), 14'(o_dma_rx_req));
      cmp("ack flag", 14'h0000, 14'(o_status[`F_ACKDEC]));
      if (o_status[`F_ADDRV] === 1'b1)
        cmp("addr byte", 14'(b), 14'(o_addr_captured));
      model.pulse(3'h2);
      wr(0, `CLEARABLE);
    end
    i_bcast_enable <= 1'b1;
    model.send_byte(1'b1, 8'h00);
    look(2);
    cmp("broadcast", 14'h0001, 14'(o_status[`F_BCAST]));
    model.pulse(3'h2);
    wr(0, `CLEARABLE);
    {i_dma_addr_en, i_ack_hold_enable, i_match_mode} <= {2'h1, `MATCH_ONE};
    for (int k = 0; k < 2; k++)
      fork
        model.send_byte(k == 0, {i_addr0, 1'b0});
        begin
          look(4);
          cmp("scl hold", 14'h0001, 14'(o_scl_hold));
          cmp("ack flag", 14'h0001, 14'(o_status[`F_ACKDEC]));
          wr(2, 14'(k));
        end
      join
    tick(1);
    {i_ack_hold_enable, i_dma_rx_en} <= 2'h1;
    d[0] = {i_addr0, 1'b0};
    // far side ignores ready here to force an overflow
    for (int i = 1; i <= `FIFO_DEPTH; i++)
    begin
      d[i] = 8'($urandom());
      model.send_byte(1'b0, d[i]);
    end
    look(3);
    cmp("full ready", 14'h0000, 14'(o_rx_ready));
    cmp("rx flags", 14'h0082, o_status & 14'h0082);
    cmp("rx dma", 14'h0001, 14'(o_dma_rx_req));
    for (int i = 0; i < `FIFO_DEPTH; i++)
    begin
      cmp("rx data", 14'(d[i]), 14'(o_rx_data));
      tick(1);
      i_rx_pop <= 1'b1;
      tick(1);
      i_rx_pop <= 1'b0;
      look(2);
    end
    cmp("empty ready", 14'h0001, 14'(o_rx_ready));
    cmp("rx dma idle", 14'h0000, 14'(o_dma_rx_req));
    cmp("rx flag", 14'h0000, o_status & 14'h0002);
    cmp("ack left", 14'h0000, 14'(exp_q.size()));
    tally_and_finish();
  end
endmodule
